// *** pkg/bdpr_pkg.sv ***
// Shared constants and types of the bridge data parity reporting block
package bdpr_pkg;

	// Register byte offsets on the AHB-Lite slave
	localparam logic [7:0] BDPR_CTRL_OFS    = 8'h00;
	localparam logic [7:0] BDPR_STATUS_OFS  = 8'h04;
	localparam logic [7:0] BDPR_MASK_OFS    = 8'h08;
	localparam int         BDPR_ADDR_BITS   = 8;

	// Control register fields
	localparam int BDPR_CTRL_PRI_RESP   = 0;   // Primary parity error response enable
	localparam int BDPR_CTRL_SERR_EN    = 1;   // System error enable
	localparam int BDPR_CTRL_SEC_RESP   = 2;   // Secondary parity error response enable
	localparam int BDPR_CTRL_PW_DISABLE = 3;   // Posted write parity event disable
	localparam int BDPR_CTRL_BITS       = 4;
	localparam logic [3:0] BDPR_CTRL_RESET = 4'h0;

	// Status and mask register fields (same layout)
	localparam int BDPR_ST_SEC_MDP  = 0;       // Secondary master data parity detected
	localparam int BDPR_ST_SIG_SERR = 1;       // Signaled system error
	localparam int BDPR_ST_PRI_PERR = 2;       // Primary parity error line asserted
	localparam int BDPR_ST_SEC_PERR = 3;       // Secondary parity error line asserted
	localparam int BDPR_ST_BITS     = 4;
	localparam logic [3:0] BDPR_ST_RESET   = 4'h0;
	localparam logic [3:0] BDPR_MASK_RESET = 4'h0;

	// Transaction kinds reported by the bridge core
	localparam logic [1:0] BDPR_KIND_READ    = 2'h0;
	localparam logic [1:0] BDPR_KIND_POSTED  = 2'h1;
	localparam logic [1:0] BDPR_KIND_DELAYED = 2'h2;

	// Parity line indices
	localparam int BDPR_PRI   = 0;
	localparam int BDPR_SEC   = 1;
	localparam int BDPR_LINES = 2;

	// AHB constants and synchroniser depth
	localparam logic [1:0] BDPR_HTRANS_NONSEQ = 2'h2;
	localparam logic       BDPR_HRESP_OKAY    = 1'h0;
	localparam int         BDPR_SYNC_STAGES   = 2;

	// Parity error line drive sequence: low for one cycle, then high, then released
	typedef enum logic [1:0] {
		BDPR_PERR_IDLE,
		BDPR_PERR_LOW,
		BDPR_PERR_HIGH
	} bdpr_perr_state_t;

endpackage : bdpr_pkg

// *** hdl/bdpr_sync.sv ***
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module bdpr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input  wire logic             clk,      // Sampling clock
	input  wire logic             rst_n,    // Asynchronous reset, active low
	input  wire logic [WIDTH-1:0] d,        // Asynchronous levels
	output logic      [WIDTH-1:0] q         // Synchronised levels
);

	logic [WIDTH-1:0] meta;

	// First stage feeds only the second; idle PCI lines are high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= RESET_VALUE;
			q    <= RESET_VALUE;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : bdpr_sync

// *** hdl/bdpr_ahb_slave.sv ***
// AHB-Lite slave front end: address phase capture and data phase strobes
`timescale 1ns/1ps
module bdpr_ahb_slave (
	input  wire logic        hclk,       // Bus clock
	input  wire logic        hresetn,    // Asynchronous reset, active low
	input  wire logic        hsel,       // Slave select
	input  wire logic [31:0] haddr,      // Byte address
	input  wire logic [1:0]  htrans,     // Transfer type
	input  wire logic        hwrite,     // Write when high
	input  wire logic        hready,     // Bus ready in
	output logic             wr_en,      // Data phase write strobe
	output logic             rd_en,      // Data phase read strobe
	output logic [7:0]       dp_addr     // Data phase byte address
);

	logic dp_write;
	logic dp_valid;
	wire  ap_take = hsel & hready & htrans[1];

	// Capture each address phase; the slave never inserts waits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready) begin
			dp_valid <= ap_take;
			dp_write <= hwrite;
			dp_addr  <= haddr[bdpr_pkg::BDPR_ADDR_BITS-1:0];
		end
	end

	// Strobes last exactly the one data phase cycle
	assign wr_en = dp_valid & dp_write;
	assign rd_en = dp_valid & ~dp_write;

endmodule : bdpr_ahb_slave

// *** hdl/bdpr_top.sv ***
// Data parity error reporting of a two-port bridge, with AHB-Lite registers
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

// Operation
// - Master data parity bit only for transactions the bridge masters on secondary
// - Set it on seen secondary parity line or secondary parity error, downstream
// - Set it only while secondary parity response enable is one
// - Drive primary parity line only as write target or read initiator there
// - Assert primary parity line only with primary parity response enable
// - Primary parity error on upstream read, downstream posted or delayed write
// - Seen secondary line on downstream delayed write asserts primary line, both enables
// - Drive secondary line as write target or read initiator, secondary enable set
// - Secondary parity error on downstream read, upstream posted or delayed write
// - Seen primary line on upstream delayed write asserts secondary line, both enables
// - System error for parity only on posted writes reported by the target bus
// - No system error when the bridge itself found the error as target
// - System error for posted write parity needs both parity response enables
// - System error for posted write parity needs the system error enable
// - Raising the system error line also sets the signaled system error bit
// - Posted write event disable suppresses downstream posted write system error
module bdpr_top (
	input  wire logic        hclk,                           // Bus clock, 200 MHz
	input  wire logic        hresetn,                        // Async reset, active low
	input  wire logic        hsel,                           // AHB slave select
	input  wire logic [31:0] haddr,                          // AHB byte address
	input  wire logic [1:0]  htrans,                         // AHB transfer type
	input  wire logic        hwrite,                         // AHB write when high
	input  wire logic [2:0]  hsize,                          // AHB size, word only
	input  wire logic [31:0] hwdata,                         // AHB write data
	input  wire logic        hready,                         // AHB ready in
	output logic             hreadyout,                      // AHB ready out
	output logic             hresp,                          // AHB response
	output logic [31:0]      hrdata,                         // AHB read data
	input  wire logic        xfer_active,                    // Core: transaction in flight
	input  wire logic [1:0]  xfer_kind,                      // Core: read, posted, delayed
	input  wire logic        xfer_upstream,                  // Core: 1 upstream, 0 down
	input  wire logic        pri_parity_det,                 // Core: parity bad on primary
	input  wire logic        sec_parity_det,                 // Core: parity bad on secondary
	input  wire logic        primary_parity_error_n_in,      // Primary parity line pin
	output logic             primary_parity_error_n_out,     // Primary parity line drive
	output logic             primary_parity_error_n_oe,      // Primary parity line enable
	input  wire logic        secondary_parity_error_n_in,    // Secondary parity line pin
	output logic             secondary_parity_error_n_out,   // Secondary parity line drive
	output logic             secondary_parity_error_n_oe,    // Secondary parity line enable
	output logic             primary_system_error_n_out,     // System error drive, low
	output logic             primary_system_error_n_oe,      // System error enable
	output logic             irq                             // Interrupt, active high
);

	// Register file
	logic [bdpr_pkg::BDPR_CTRL_BITS-1:0] ctrl;
	logic [bdpr_pkg::BDPR_ST_BITS-1:0]   status;
	logic [bdpr_pkg::BDPR_ST_BITS-1:0]   mask;
	logic [bdpr_pkg::BDPR_ST_BITS-1:0]   next_status;

	// Bus front end
	logic       wr_en;
	logic       rd_en;
	logic [7:0] dp_addr;

	// Synchronised parity line levels
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_pin_n;
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_pin_sync_n;

	// Per-line drive sequencers
	bdpr_pkg::bdpr_perr_state_t perr_state [bdpr_pkg::BDPR_LINES];
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_req;
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_drive_low;
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_drive;
	logic [bdpr_pkg::BDPR_LINES-1:0] perr_seen;
	logic [bdpr_pkg::BDPR_LINES-1:0] drive_d1;
	logic [bdpr_pkg::BDPR_LINES-1:0] drive_d2;

	// Self-detected posted write errors on the initiator bus
	logic self_detected;
	logic serr_pulse;

	bdpr_ahb_slave u_slave (
		.hclk    (hclk),
		.hresetn (hresetn),
		.hsel    (hsel),
		.haddr   (haddr),
		.htrans  (htrans),
		.hwrite  (hwrite),
		.hready  (hready),
		.wr_en   (wr_en),
		.rd_en   (rd_en),
		.dp_addr (dp_addr)
	);

	assign perr_pin_n[bdpr_pkg::BDPR_PRI] = primary_parity_error_n_in;
	assign perr_pin_n[bdpr_pkg::BDPR_SEC] = secondary_parity_error_n_in;

	// Pins come from the PCI clock domains, so they are synchronised first
	bdpr_sync #(
		.WIDTH       (bdpr_pkg::BDPR_LINES),
		.RESET_VALUE ('1)
	) u_sync (
		.clk   (hclk),
		.rst_n (hresetn),
		.d     (perr_pin_n),
		.q     (perr_pin_sync_n)
	);

	// Decoded enables from the control register
	wire pri_resp_en   = ctrl[bdpr_pkg::BDPR_CTRL_PRI_RESP];
	wire sec_resp_en   = ctrl[bdpr_pkg::BDPR_CTRL_SEC_RESP];
	wire serr_en       = ctrl[bdpr_pkg::BDPR_CTRL_SERR_EN];
	wire pw_disable    = ctrl[bdpr_pkg::BDPR_CTRL_PW_DISABLE];

	// Transaction classification
	wire is_read       = xfer_kind == bdpr_pkg::BDPR_KIND_READ;
	wire is_posted     = xfer_kind == bdpr_pkg::BDPR_KIND_POSTED;
	wire is_delayed    = xfer_kind == bdpr_pkg::BDPR_KIND_DELAYED;
	wire is_write      = is_posted | is_delayed;
	wire is_down       = ~xfer_upstream;
	wire is_up         = xfer_upstream;
	wire known_kind    = is_read | is_write;
	wire xfer_ok       = xfer_active & known_kind;

	// Own drive delayed by the sync stages: the pin level read here lags the drive
	// by two cycles, so the bridge's own low must be matched against that history
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drive_d1 <= '0;
			drive_d2 <= '0;
		end else begin
			drive_d1 <= perr_drive;
			drive_d2 <= drive_d1;
		end
	end

	// A line driven by the bridge itself is not counted as another agent's report
	assign perr_seen[bdpr_pkg::BDPR_PRI] = ~perr_pin_sync_n[bdpr_pkg::BDPR_PRI]
		& ~drive_d2[bdpr_pkg::BDPR_PRI];
	assign perr_seen[bdpr_pkg::BDPR_SEC] = ~perr_pin_sync_n[bdpr_pkg::BDPR_SEC]
		& ~drive_d2[bdpr_pkg::BDPR_SEC];

	wire p_seen = perr_seen[bdpr_pkg::BDPR_PRI] & xfer_ok;
	wire s_seen = perr_seen[bdpr_pkg::BDPR_SEC] & xfer_ok;
	wire p_det  = pri_parity_det & xfer_ok;
	wire s_det  = sec_parity_det & xfer_ok;

	// Bridge is master on secondary exactly for downstream transactions
	wire sec_master = is_down;

	// Secondary master data parity detected event
	wire ev_sec_mdp = sec_master & sec_resp_en & (s_seen | s_det);

	// Bridge as write target or read initiator on the primary bus
	wire pri_perr_role = (is_up & is_read) | (is_down & is_write);

	// Primary line: own detection or forwarded delayed write completion report
	wire pri_own_err = pri_perr_role & p_det;
	wire pri_fwd_err = is_down & is_delayed & s_seen & sec_resp_en;
	assign perr_req[bdpr_pkg::BDPR_PRI] = pri_resp_en
		& (pri_own_err | pri_fwd_err);

	// Bridge as write target or read initiator on the secondary bus
	wire sec_perr_role = (is_down & is_read) | (is_up & is_write);

	// Secondary line: own detection or forwarded delayed write completion report
	wire sec_own_err = sec_perr_role & s_det;
	wire sec_fwd_err = is_up & is_delayed & p_seen & pri_resp_en;
	assign perr_req[bdpr_pkg::BDPR_SEC] = sec_resp_en
		& (sec_own_err | sec_fwd_err);

	// Initiator-bus detection of a posted write marks the error as already known
	wire self_det_now = is_posted & ((is_up & s_det) | (is_down & p_det));

	// Remember self detection for the rest of the transaction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			self_detected <= 1'b0;
		end else begin
			self_detected <= xfer_active & (self_detected | self_det_now);
		end
	end

	// Target bus reports on posted writes only; reads and delayed writes never count
	wire serr_up   = is_up & p_seen;
	wire serr_down = is_down & s_seen & ~pw_disable;
	wire serr_src  = is_posted & (serr_up | serr_down);
	wire serr_known = self_detected | self_det_now;
	wire serr_resp = pri_resp_en & sec_resp_en;
	wire ev_serr   = serr_src & ~serr_known & serr_resp & serr_en;

	// One-cycle system error pulse per reported event
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serr_pulse <= 1'b0;
		end else begin
			serr_pulse <= ev_serr;
		end
	end

	// Open-drain system error: enable only while pulling low
	assign primary_system_error_n_out = 1'b0;
	assign primary_system_error_n_oe  = serr_pulse;

	// Parity lines: drive low for one cycle, then high for one, then release.
	// The high cycle returns the shared line to its idle level before letting go.
	genvar g;
	generate
		for (g = 0; g < bdpr_pkg::BDPR_LINES; g++) begin : g_perr
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					perr_state[g] <= bdpr_pkg::BDPR_PERR_IDLE;
				end else begin
					unique case (perr_state[g])
						bdpr_pkg::BDPR_PERR_IDLE: begin
							if (perr_req[g]) begin
								perr_state[g] <= bdpr_pkg::BDPR_PERR_LOW;
							end
						end
						bdpr_pkg::BDPR_PERR_LOW: begin
							perr_state[g] <= bdpr_pkg::BDPR_PERR_HIGH;
						end
						bdpr_pkg::BDPR_PERR_HIGH: begin
							if (perr_req[g]) begin
								perr_state[g] <= bdpr_pkg::BDPR_PERR_LOW;
							end else begin
								perr_state[g] <= bdpr_pkg::BDPR_PERR_IDLE;
							end
						end
						default: begin
							perr_state[g] <= bdpr_pkg::BDPR_PERR_IDLE;
						end
					endcase
				end
			end

			assign perr_drive_low[g] = perr_state[g] == bdpr_pkg::BDPR_PERR_LOW;
			assign perr_drive[g]     = perr_state[g] != bdpr_pkg::BDPR_PERR_IDLE;
		end
	endgenerate

	// Parity line pins
	assign primary_parity_error_n_out   = ~perr_drive_low[bdpr_pkg::BDPR_PRI];
	assign primary_parity_error_n_oe    = perr_drive[bdpr_pkg::BDPR_PRI];
	assign secondary_parity_error_n_out = ~perr_drive_low[bdpr_pkg::BDPR_SEC];
	assign secondary_parity_error_n_oe  = perr_drive[bdpr_pkg::BDPR_SEC];

	// Register address decode
	wire sel_ctrl   = dp_addr == bdpr_pkg::BDPR_CTRL_OFS;
	wire sel_status = dp_addr == bdpr_pkg::BDPR_STATUS_OFS;
	wire sel_mask   = dp_addr == bdpr_pkg::BDPR_MASK_OFS;

	wire wr_ctrl   = wr_en & sel_ctrl;
	wire wr_status = wr_en & sel_status;
	wire wr_mask   = wr_en & sel_mask;

	// Hardware events feeding the sticky status bits
	wire [bdpr_pkg::BDPR_ST_BITS-1:0] status_set;
	assign status_set[bdpr_pkg::BDPR_ST_SEC_MDP]  = ev_sec_mdp;
	assign status_set[bdpr_pkg::BDPR_ST_SIG_SERR] = serr_pulse;
	assign status_set[bdpr_pkg::BDPR_ST_PRI_PERR] = perr_drive_low[bdpr_pkg::BDPR_PRI];
	assign status_set[bdpr_pkg::BDPR_ST_SEC_PERR] = perr_drive_low[bdpr_pkg::BDPR_SEC];

	// Write one to clear; a set in the same cycle wins so no event is lost
	wire [bdpr_pkg::BDPR_ST_BITS-1:0] status_clr =
		wr_status ? hwdata[bdpr_pkg::BDPR_ST_BITS-1:0] : '0;

	always_comb begin
		next_status = (status & ~status_clr) | status_set;
	end

	// Control, status and mask registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl   <= bdpr_pkg::BDPR_CTRL_RESET;
			status <= bdpr_pkg::BDPR_ST_RESET;
			mask   <= bdpr_pkg::BDPR_MASK_RESET;
		end else begin
			status <= next_status;
			if (wr_ctrl) begin
				ctrl <= hwdata[bdpr_pkg::BDPR_CTRL_BITS-1:0];
			end
			if (wr_mask) begin
				mask <= hwdata[bdpr_pkg::BDPR_ST_BITS-1:0];
			end
		end
	end

	// Level interrupt while any unmasked status bit stands; mask bit 1 enables
	assign irq = |(status & mask);

	// Read mux; unmapped offsets read as zero with an OKAY answer
	wire [31:0] rd_ctrl   = {{(32 - bdpr_pkg::BDPR_CTRL_BITS){1'b0}}, ctrl};
	wire [31:0] rd_status = {{(32 - bdpr_pkg::BDPR_ST_BITS){1'b0}}, status};
	wire [31:0] rd_mask   = {{(32 - bdpr_pkg::BDPR_ST_BITS){1'b0}}, mask};

	assign hrdata = !rd_en     ? 32'h00000000 :
	                sel_ctrl   ? rd_ctrl :
	                sel_status ? rd_status :
	                sel_mask   ? rd_mask : 32'h00000000;

	// Zero wait states: every access completes in its first data phase cycle
	assign hreadyout = 1'b1;
	assign hresp     = bdpr_pkg::BDPR_HRESP_OKAY;

endmodule : bdpr_top

// *** sim/bdpr_props.sv ***
// Port-level checks of the bridge data parity reporting block
`timescale 1ns/1ps
module bdpr_props (
	input wire logic        hclk,                         // Bus clock
	input wire logic        hresetn,                      // Reset, active low
	input wire logic        hsel,                         // Select
	input wire logic [1:0]  htrans,                       // Transfer type
	input wire logic        hwrite,                       // Write
	input wire logic        hready,                       // Ready in
	input wire logic        hreadyout,                    // Ready out
	input wire logic        hresp,                        // Response
	input wire logic [31:0] hrdata,                       // Read data
	input wire logic        xfer_active,                  // Transaction in flight
	input wire logic [1:0]  xfer_kind,                    // Transaction kind
	input wire logic        xfer_upstream,                // Direction
	input wire logic        pri_parity_det,               // Primary detect
	input wire logic        sec_parity_det,               // Secondary detect
	input wire logic        primary_parity_error_n_out,   // Primary drive
	input wire logic        primary_parity_error_n_oe,    // Primary enable
	input wire logic        secondary_parity_error_n_out, // Secondary drive
	input wire logic        secondary_parity_error_n_oe,  // Secondary enable
	input wire logic        primary_system_error_n_out,   // System error drive
	input wire logic        primary_system_error_n_oe     // System error enable
);
	logic rd_dp;
	wire  p_low = primary_parity_error_n_oe & ~primary_parity_error_n_out;
	wire  s_low = secondary_parity_error_n_oe & ~secondary_parity_error_n_out;
	// Read data phase marker; outside it the read bus must sit at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_dp <= 1'b0;
		else
			rd_dp <= hsel & hready & htrans[1] & ~hwrite;
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_p_high; primary_parity_error_n_oe && primary_parity_error_n_out; endsequence
	sequence s_p_end; !primary_parity_error_n_oe || p_low; endsequence
	property p_pri_seq; $rose(p_low) |=> s_p_high ##1 s_p_end; endproperty
	a_pri_seq: assert property (p_pri_seq) else $error("primary drive not low high release");
	property p_pri_dir; $rose(p_low) |-> $past(xfer_active) && $past(xfer_kind) != 2'h3
		&& (($past(xfer_kind) == bdpr_pkg::BDPR_KIND_READ) == $past(xfer_upstream)); endproperty
	a_pri_dir: assert property (p_pri_dir) else $error("primary drive in wrong role");
	property p_sec_dir; $rose(s_low) |-> $past(xfer_active) && $past(xfer_kind) != 2'h3
		&& (($past(xfer_kind) == bdpr_pkg::BDPR_KIND_READ) != $past(xfer_upstream)); endproperty
	a_sec_dir: assert property (p_sec_dir) else $error("secondary drive in wrong role");
	property p_pri_cause; $rose(p_low) |-> $past(pri_parity_det) || (!$past(xfer_upstream)
		&& $past(xfer_kind) == bdpr_pkg::BDPR_KIND_DELAYED); endproperty
	a_pri_cause: assert property (p_pri_cause) else $error("primary drive without cause");
	property p_sec_cause; $rose(s_low) |-> $past(sec_parity_det) || ($past(xfer_upstream)
		&& $past(xfer_kind) == bdpr_pkg::BDPR_KIND_DELAYED); endproperty
	a_sec_cause: assert property (p_sec_cause) else $error("secondary drive without cause");
	property primary_system_error_n_kind; primary_system_error_n_oe |-> $past(xfer_active)
		&& $past(xfer_kind) == bdpr_pkg::BDPR_KIND_POSTED && !primary_system_error_n_out; endproperty
	a_serr_kind: assert property (primary_system_error_n_kind) else $error("system error off posted write");
	property primary_system_error_n_self; primary_system_error_n_oe && !$past(xfer_upstream)
		|-> !$past(pri_parity_det); endproperty
	a_serr_self: assert property (primary_system_error_n_self) else $error("system error on own detect");
	property p_bus_okay; hreadyout && hresp == bdpr_pkg::BDPR_HRESP_OKAY; endproperty
	a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
	property p_rdata_idle; !rd_dp |-> hrdata == 32'h0; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");
endmodule : bdpr_props
bind bdpr_top bdpr_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .xfer_active, .xfer_kind, .xfer_upstream, .pri_parity_det, .sec_parity_det,
	.primary_parity_error_n_out, .primary_parity_error_n_oe, .secondary_parity_error_n_out,
	.secondary_parity_error_n_oe, .primary_system_error_n_out, .primary_system_error_n_oe);

// *** sim/bdpr_agent.sv ***
// Far bus agents: report parity errors on the pulled-up error lines
`timescale 1ns/1ps
module bdpr_agent (
	input  wire logic pri_pull, // Primary agent reports an error
	input  wire logic sec_pull, // Secondary agent reports an error
	input  wire logic pri_oe,   // Bridge primary enable
	input  wire logic pri_out,  // Bridge primary drive
	input  wire logic sec_oe,   // Bridge secondary enable
	input  wire logic sec_out,  // Bridge secondary drive
	output logic      pri_wire, // Resolved primary line
	output logic      sec_wire  // Resolved secondary line
);
	// Wired low by either party; a released line floats back high on its pull-up
	assign pri_wire = ~((pri_oe & ~pri_out) | pri_pull);
	assign sec_wire = ~((sec_oe & ~sec_out) | sec_pull);
endmodule : bdpr_agent

// *** sim/tb_bridge_data_parity_reporting.sv ***
// Self-checking bench of the bridge data parity reporting block
`timescale 1ns/1ps
module tb_bridge_data_parity_reporting;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, xfer_active = 0, xfer_upstream = 0;
	logic pri_parity_det = 0, sec_parity_det = 0, pri_pull = 0, sec_pull = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0, xfer_kind = 0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, p_out, p_oe, s_out, s_oe, serr_out, serr_oe, irq, pw, sw;
	logic [3:0]  mask_val = 0, e, cv[3] = '{4'h7, 4'h4, 4'h1};
	int          fail_count = 0, check_count = 0, c, k, u, b;
	always #2.5 hclk = ~hclk;
	bdpr_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xfer_active(xfer_active),
		.xfer_kind(xfer_kind), .xfer_upstream(xfer_upstream), .pri_parity_det(pri_parity_det),
		.sec_parity_det(sec_parity_det), .primary_parity_error_n_in(pw),
		.primary_parity_error_n_out(p_out), .primary_parity_error_n_oe(p_oe),
		.secondary_parity_error_n_in(sw), .secondary_parity_error_n_out(s_out),
		.secondary_parity_error_n_oe(s_oe), .primary_system_error_n_out(serr_out),
		.primary_system_error_n_oe(serr_oe), .irq(irq));
	bdpr_agent u_agent (.pri_pull(pri_pull), .sec_pull(sec_pull), .pri_oe(p_oe), .pri_out(p_out),
		.sec_oe(s_oe), .sec_out(s_out), .pri_wire(pw), .sec_wire(sw));
	task close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Bounded wait for hready; a hang ends the run through the verdict
	task wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			$display("Error hready timeout");
			close_out();
		end
	endtask : wait_ready
	// One single word transfer; read data taken at the closing edge
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= bdpr_pkg::BDPR_HTRANS_NONSEQ;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
	endtask : ahb
	// Reset values, unmapped place, write-only-low-bits of the mask
	task regs_reset;
		ahb(0, bdpr_pkg::BDPR_CTRL_OFS, 0);
		check("ctrl reset", rd, {28'h0, bdpr_pkg::BDPR_CTRL_RESET});
		ahb(0, bdpr_pkg::BDPR_STATUS_OFS, 0);
		check("status reset", rd, {28'h0, bdpr_pkg::BDPR_ST_RESET});
		ahb(1, 8'h0C, 32'hFFFFFFFF);
		ahb(0, 8'h0C, 0);
		check("unmapped", rd, 32'h0);
		ahb(0, bdpr_pkg::BDPR_MASK_OFS, 0);
		check("mask reset", rd, {28'h0, bdpr_pkg::BDPR_MASK_RESET});
		ahb(1, bdpr_pkg::BDPR_MASK_OFS, 32'hFFFFFFFF);
		ahb(0, bdpr_pkg::BDPR_MASK_OFS, 0);
		check("mask", rd, 32'h0000000F);
		ahb(1, bdpr_pkg::BDPR_MASK_OFS, {28'h0, mask_val});
	endtask : regs_reset
	// ev: sec line, pri line, sec det, pri det; ex: sec drive, pri drive, serr, master parity
	task run_case(input logic [1:0] kd, input logic up, input logic [3:0] ctl,
		input logic [3:0] ev, input logic [3:0] ex);
		logic [3:0] seen;
		int i;
		seen = 0;
		ahb(1, bdpr_pkg::BDPR_CTRL_OFS, {28'h0, ctl});
		xfer_active <= 1'b1;
		xfer_kind <= kd;
		xfer_upstream <= up;
		@(posedge hclk);
		{sec_pull, pri_pull, sec_parity_det, pri_parity_det} <= ev;
		@(posedge hclk);
		{sec_pull, pri_pull, sec_parity_det, pri_parity_det} <= 4'h0;
		// Look from this cycle on: a detect pulse drives low in the very next cycle
		for (i = 0; i < 10; i++) begin
			#1;
			seen = seen | {s_oe & ~s_out, p_oe & ~p_out, serr_oe, 1'b0};
			@(posedge hclk);
		end
		@(posedge hclk);
		xfer_active <= 1'b0;
		@(posedge hclk);
		check("pri drive", seen[2], ex[2]);
		check("sec drive", seen[3], ex[3]);
		check("serr pulse", seen[1], ex[1]);
		ahb(0, bdpr_pkg::BDPR_STATUS_OFS, 0);
		check("status", rd, {28'h0, ex});
		check("irq", irq, |(ex & mask_val));
		ahb(1, bdpr_pkg::BDPR_STATUS_OFS, 32'hF);
		@(posedge hclk);
		check("irq clear", irq, 1'b0);
	endtask : run_case
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		regs_reset();
		// Own detection in every kind, direction and bus, under three enable sets
		for (c = 0; c < 3; c++)
			for (k = 0; k < 3; k++)
				for (u = 0; u < 2; u++)
					for (b = 0; b < 2; b++) begin
						e = b ? {((k == 0) != u[0]) & cv[c][2], 2'b0, !u[0] & cv[c][2]}
							: {1'b0, ((k == 0) == u[0]) & cv[c][0], 2'b0};
						run_case(k[1:0], u[0], cv[c], b ? 4'h2 : 4'h1, e);
					end
		mask_val = 4'hF;
		ahb(1, bdpr_pkg::BDPR_MASK_OFS, 32'hF);
		// Error lines reported by the far agents
		run_case(2'h2, 1'b0, 4'h7, 4'h8, 4'h5);
		run_case(2'h2, 1'b0, 4'h1, 4'h8, 4'h0);
		run_case(2'h2, 1'b1, 4'h7, 4'h4, 4'h8);
		run_case(2'h2, 1'b1, 4'h4, 4'h4, 4'h0);
		run_case(2'h1, 1'b0, 4'h7, 4'h8, 4'h3);
		run_case(2'h1, 1'b1, 4'h7, 4'h4, 4'h2);
		run_case(2'h1, 1'b0, 4'hF, 4'h8, 4'h1);
		run_case(2'h1, 1'b1, 4'hF, 4'h4, 4'h2);
		run_case(2'h1, 1'b1, 4'h5, 4'h4, 4'h0);
		run_case(2'h1, 1'b1, 4'h3, 4'h4, 4'h0);
		run_case(2'h1, 1'b0, 4'h7, 4'h9, 4'h5);
		run_case(2'h0, 1'b0, 4'h7, 4'h8, 4'h1);
		run_case(2'h0, 1'b1, 4'h7, 4'h4, 4'h0);
		mask_val = 4'h2;
		ahb(1, bdpr_pkg::BDPR_MASK_OFS, 32'h2);
		run_case(2'h0, 1'b0, 4'h7, 4'h2, 4'h9);
		close_out();
	end
endmodule : tb_bridge_data_parity_reporting
